// >>> design/palette_pkg.sv
// Purpose: Shared constants for the colour table access port
// Assumes: 8-bit register port, single clock
// Notes:   Offsets are byte addresses on the plain register port
package palette_pkg;
    localparam int          ADDR_W          = 9;
    localparam int          DATA_W          = 8;
    localparam logic [8:0]  OFF_SELECT      = 9'h1e0;
    localparam logic [8:0]  OFF_INDEX       = 9'h1e2;
    localparam logic [8:0]  OFF_VALUE       = 9'h1e4;
    localparam logic [1:0]  SEL_BOTH        = 2'h0;
    localparam logic [1:0]  SEL_PANEL       = 2'h1;
    localparam logic [1:0]  SEL_CRT         = 2'h2;
    localparam logic [1:0]  SELECT_RESET    = 2'h0;
    localparam logic [7:0]  INDEX_RESET     = 8'h00;
    localparam int          VALUE_LSB       = 4;
    localparam int          ENTRIES         = 256;
    localparam int          COMP_W          = 4;
    typedef enum logic [1:0] {
        COMP_RED,
        COMP_GREEN,
        COMP_BLUE
    } comp_type;
endpackage : palette_pkg

// >>> design/palette_store_if.sv
// Purpose: Carries table-set write and lookup signals
// Assumes: One clock
// Notes:   Used between the port and one table set
interface palette_store_if #(
    parameter int IDX_W = 8,
    parameter int CW    = 4
);
    logic             wr_en;
    logic [IDX_W-1:0] wr_idx;
    logic [3*CW-1:0]  wr_rgb;
    logic [IDX_W-1:0] rd_idx;
    logic [3*CW-1:0]  rd_rgb;
    modport port  (output wr_en, output wr_idx, output wr_rgb, output rd_idx, input rd_rgb);
    modport store (input wr_en, input wr_idx, input wr_rgb, input rd_idx, output rd_rgb);
endinterface : palette_store_if

// >>> design/palette_store.sv
// Purpose: One colour table set with red, green and blue tables
// Assumes: Runs on the port clock; the pixel clock domain is outside
// Notes:   Asynchronous read so that a data read answers in one cycle
module palette_store #(
    parameter int ENTRIES = 256,
    parameter int CW      = 4
) (
    // Clock
    input wire logic        mclk,
    // Table access
    palette_store_if.store  bus
);
    logic [3*CW-1:0] table_mem [ENTRIES];

    if (ENTRIES < 2 || CW < 1) begin : bad_size_g
        $error("palette_store: bad size");
    end

    // Red, green and blue stored as one triple per entry
    always_ff @(posedge mclk) begin
        if (bus.wr_en) begin
            table_mem[bus.wr_idx] <= bus.wr_rgb;
        end
    end

    assign bus.rd_rgb = table_mem[bus.rd_idx];
endmodule : palette_store

// >>> design/palette_table_access_port.sv
// Purpose: Register access port to the panel and CRT/TV colour tables
// Assumes: Plain register port; read data valid the cycle after a read strobe
// Notes:   Reserved select code 11 writes nothing and data register reads return zero
// Function
// R01: Select 00 reads panel and writes both sets, 01 panel only, 10 CRT/TV only, 11 reserved.
// R02: Each set has red, green and blue tables of 256 four-bit entries.
// R03: Writing the index register loads the pointer and sets the colour position to red.
// R04: Each data access advances red, green, blue, then red of the next index.
// R05: Red and green are held and the entry is written only when blue is written.
// R06: The component sits in data bits 7-4 and bits 3-0 are unused.
// R07: The system keeps each set's pixel clock running while that set is accessed.
// R08: Past blue of entry 255 the pointer wraps to red of entry 0.
//
// Implementation choice: strobed register access.
module palette_table_access_port #(
    parameter int ENTRIES = palette_pkg::ENTRIES,
    parameter int CW      = palette_pkg::COMP_W
) (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst,
    // Register port
    input  wire logic [palette_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [palette_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [palette_pkg::DATA_W-1:0] reg_rdata,
    // Display pixel lookups
    input  wire logic [7:0]                  panel_pix_idx,
    output logic      [3*CW-1:0]             panel_pix_rgb,
    input  wire logic [7:0]                  crt_pix_idx,
    output logic      [3*CW-1:0]             crt_pix_rgb
);
    if (ENTRIES != 256 || CW != 4) begin : bad_size_g
        $error("palette_table_access_port: only 256 x 4-bit tables supported");
    end

    palette_store_if #(.IDX_W(8), .CW(CW)) panel_if ();
    palette_store_if #(.IDX_W(8), .CW(CW)) crt_if ();

    palette_store #(.ENTRIES(ENTRIES), .CW(CW)) u_panel ( // [R02]
        .mclk (mclk),
        .bus  (panel_if.store)
    );
    palette_store #(.ENTRIES(ENTRIES), .CW(CW)) u_crt ( // [R02]
        .mclk (mclk),
        .bus  (crt_if.store)
    );

    logic [1:0]                   table_select_bits;
    logic [7:0]                   entry_index_bits;
    palette_pkg::comp_type        comp;
    logic [CW-1:0]                hold_red;
    logic [CW-1:0]                hold_green;
    logic [palette_pkg::DATA_W-1:0] rdata_q;
    logic [1:0]                   next_select;
    logic [7:0]                   next_index;
    palette_pkg::comp_type        next_comp;
    logic [CW-1:0]                next_red;
    logic [CW-1:0]                next_green;
    logic [palette_pkg::DATA_W-1:0] next_rdata;
    logic                         hit_sel;
    logic                         hit_idx;
    logic                         hit_val;
    logic                         commit;
    logic [3*CW-1:0]              read_rgb;
    logic [CW-1:0]                read_comp;
    logic [CW-1:0]                wr_comp;

    function automatic logic [CW-1:0] pick(input logic [3*CW-1:0] rgb, input palette_pkg::comp_type c);
        logic [CW-1:0] r;
        r = rgb[3*CW-1 -: CW];
        case (c)
            palette_pkg::COMP_GREEN: r = rgb[2*CW-1 -: CW];
            palette_pkg::COMP_BLUE:  r = rgb[CW-1:0];
            default:                 r = rgb[3*CW-1 -: CW];
        endcase
        return r;
    endfunction : pick

    // Address decode
    always_comb begin
        hit_sel = 1'b0;
        hit_idx = 1'b0;
        hit_val = 1'b0;
        if (reg_addr == palette_pkg::OFF_SELECT) begin
            hit_sel = 1'b1;
        end else if (reg_addr == palette_pkg::OFF_INDEX) begin
            hit_idx = 1'b1;
        end else if (reg_addr == palette_pkg::OFF_VALUE) begin
            hit_val = 1'b1;
        end
    end

    assign wr_comp = reg_wdata[palette_pkg::VALUE_LSB +: CW]; // [R06]
    assign commit  = reg_wr && hit_val && comp == palette_pkg::COMP_BLUE; // [R05]

    // Panel is the read source for 00 and 01, CRT/TV for 10
    always_comb begin
        read_rgb = panel_if.rd_rgb; // [R01]
        if (table_select_bits == palette_pkg::SEL_CRT) begin
            read_rgb = crt_if.rd_rgb; // [R01]
        end
        read_comp = pick(read_rgb, comp);
    end

    // Table write routing
    assign panel_if.wr_en  = commit && (table_select_bits == palette_pkg::SEL_BOTH
                             || table_select_bits == palette_pkg::SEL_PANEL); // [R01]
    assign crt_if.wr_en    = commit && (table_select_bits == palette_pkg::SEL_BOTH
                             || table_select_bits == palette_pkg::SEL_CRT); // [R01]
    assign panel_if.wr_idx = entry_index_bits;
    assign crt_if.wr_idx   = entry_index_bits;
    assign panel_if.wr_rgb = {hold_red, hold_green, wr_comp}; // [R05]
    assign crt_if.wr_rgb   = {hold_red, hold_green, wr_comp};
    // Port read looks up both table sets on the pointer index; pixel lookups read separate copies
    assign panel_if.rd_idx = entry_index_bits;
    assign crt_if.rd_idx   = entry_index_bits;

    // Next-state for pointer, holds and read data
    always_comb begin
        next_select = table_select_bits;
        next_index  = entry_index_bits;
        next_comp   = comp;
        next_red    = hold_red;
        next_green  = hold_green;
        next_rdata  = '0;
        if (reg_wr) begin
            if (hit_sel) begin
                next_select = reg_wdata[1:0];
            end else if (hit_idx) begin
                next_index = reg_wdata; // [R03]
                next_comp  = palette_pkg::COMP_RED; // [R03]
            end else if (hit_val) begin
                if (comp == palette_pkg::COMP_RED) begin
                    next_red = wr_comp; // [R05]
                end else if (comp == palette_pkg::COMP_GREEN) begin
                    next_green = wr_comp; // [R05]
                end
            end
        end
        if (reg_rd) begin
            if (hit_sel) begin
                next_rdata = {6'h00, table_select_bits};
            end else if (hit_idx) begin
                next_rdata = entry_index_bits;
            end else if (hit_val && table_select_bits != 2'h3) begin
                next_rdata = {read_comp, 4'h0}; // [R06]
            end
        end
        if ((reg_wr || reg_rd) && hit_val) begin
            case (comp)
                palette_pkg::COMP_RED:   next_comp = palette_pkg::COMP_GREEN; // [R04]
                palette_pkg::COMP_GREEN: next_comp = palette_pkg::COMP_BLUE; // [R04]
                default: begin
                    next_comp  = palette_pkg::COMP_RED; // [R04]
                    next_index = 8'(entry_index_bits + 8'h01); // [R08]
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            table_select_bits <= palette_pkg::SELECT_RESET;
            entry_index_bits  <= palette_pkg::INDEX_RESET;
            comp              <= palette_pkg::COMP_RED;
            hold_red          <= '0;
            hold_green        <= '0;
            rdata_q           <= '0;
        end else begin
            table_select_bits <= next_select;
            entry_index_bits  <= next_index;
            comp              <= next_comp;
            hold_red          <= next_red;
            hold_green        <= next_green;
            rdata_q           <= next_rdata;
        end
    end

    assign reg_rdata = rdata_q;

    // Pixel lookups registered; pixel clock domain is assumed the port clock here [R07]
    logic [3*CW-1:0] panel_q;
    logic [3*CW-1:0] crt_q;
    logic [3*CW-1:0] panel_mem [ENTRIES];
    logic [3*CW-1:0] crt_mem [ENTRIES];
    always_ff @(posedge mclk) begin
        if (panel_if.wr_en) begin
            panel_mem[entry_index_bits] <= panel_if.wr_rgb;
        end
        if (crt_if.wr_en) begin
            crt_mem[entry_index_bits] <= crt_if.wr_rgb;
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            panel_q <= '0;
            crt_q   <= '0;
        end else begin
            panel_q <= panel_mem[panel_pix_idx];
            crt_q   <= crt_mem[crt_pix_idx];
        end
    end
    assign panel_pix_rgb = panel_q;
    assign crt_pix_rgb   = crt_q;

    // Assertions: register loads and pointer walk
    select_load_a: assert property (@(posedge mclk) disable iff (rst) // [R01]
        reg_wr && hit_sel |=> table_select_bits == $past(reg_wdata[1:0]))
        else $error("select load failed");

    index_load_a: assert property (@(posedge mclk) disable iff (rst) // [R03]
        reg_wr && hit_idx |=> entry_index_bits == $past(reg_wdata) && comp == palette_pkg::COMP_RED)
        else $error("index load failed");

    advance_red_a: assert property (@(posedge mclk) disable iff (rst) // [R04]
        (reg_wr || reg_rd) && hit_val && comp == palette_pkg::COMP_RED |=> comp == palette_pkg::COMP_GREEN)
        else $error("pointer did not advance");

    advance_green_a: assert property (@(posedge mclk) disable iff (rst) // [R04]
        (reg_wr || reg_rd) && hit_val && comp == palette_pkg::COMP_GREEN
        |=> comp == palette_pkg::COMP_BLUE && $stable(entry_index_bits))
        else $error("pointer did not reach blue");

    advance_blue_a: assert property (@(posedge mclk) disable iff (rst) // [R04]
        (reg_wr || reg_rd) && hit_val && comp == palette_pkg::COMP_BLUE
        |=> comp == palette_pkg::COMP_RED && entry_index_bits == 8'($past(entry_index_bits) + 8'h01))
        else $error("pointer did not move to next entry");

    index_wrap_a: assert property (@(posedge mclk) disable iff (rst) // [R08]
        (reg_wr || reg_rd) && hit_val && comp == palette_pkg::COMP_BLUE && entry_index_bits == 8'hff
        |=> entry_index_bits == 8'h00 && comp == palette_pkg::COMP_RED)
        else $error("pointer wrap failed");

    pointer_hold_a: assert property (@(posedge mclk) disable iff (rst) // [R04]
        !reg_wr && !reg_rd |=> $stable(entry_index_bits) && $stable(comp))
        else $error("pointer moved without access");

    // Assertions: held components and commit
    hold_red_a: assert property (@(posedge mclk) disable iff (rst) // [R05]
        reg_wr && hit_val && comp == palette_pkg::COMP_RED |=> hold_red == $past(wr_comp))
        else $error("red not held");

    hold_green_a: assert property (@(posedge mclk) disable iff (rst) // [R05]
        reg_wr && hit_val && comp == palette_pkg::COMP_GREEN |=> hold_green == $past(wr_comp))
        else $error("green not held");

    hold_keep_a: assert property (@(posedge mclk) disable iff (rst) // [R05]
        !(reg_wr && hit_val) |=> $stable(hold_red) && $stable(hold_green))
        else $error("held component changed");

    commit_only_blue_a: assert property (@(posedge mclk) disable iff (rst) // [R05]
        (panel_if.wr_en || crt_if.wr_en) |-> comp == palette_pkg::COMP_BLUE && reg_wr)
        else $error("commit without blue");

    panel_store_a: assert property (@(posedge mclk) disable iff (rst) // [R02]
        panel_if.wr_en
        |=> panel_mem[$past(entry_index_bits)] == {$past(hold_red), $past(hold_green), $past(wr_comp)})
        else $error("panel entry not stored");

    crt_store_a: assert property (@(posedge mclk) disable iff (rst) // [R02]
        crt_if.wr_en
        |=> crt_mem[$past(entry_index_bits)] == {$past(hold_red), $past(hold_green), $past(wr_comp)})
        else $error("crt entry not stored");

    // Assertions: table routing and read data
    route_both_a: assert property (@(posedge mclk) disable iff (rst) // [R01]
        commit && table_select_bits == palette_pkg::SEL_BOTH |-> panel_if.wr_en && crt_if.wr_en)
        else $error("both sets not written");

    route_panel_a: assert property (@(posedge mclk) disable iff (rst) // [R01]
        table_select_bits == palette_pkg::SEL_PANEL |-> !crt_if.wr_en)
        else $error("crt written in panel mode");

    route_crt_a: assert property (@(posedge mclk) disable iff (rst) // [R01]
        table_select_bits == palette_pkg::SEL_CRT |-> !panel_if.wr_en)
        else $error("panel written in crt mode");

    reserved_write_a: assert property (@(posedge mclk) disable iff (rst) // [R01]
        table_select_bits == 2'h3 |-> !panel_if.wr_en && !crt_if.wr_en)
        else $error("table written in reserved mode");

    reserved_read_a: assert property (@(posedge mclk) disable iff (rst) // [R01]
        reg_rd && hit_val && table_select_bits == 2'h3 |=> reg_rdata == 8'h00)
        else $error("reserved mode read not zero");

    panel_read_a: assert property (@(posedge mclk) disable iff (rst) // [R01]
        reg_rd && hit_val && (table_select_bits == palette_pkg::SEL_BOTH || table_select_bits == palette_pkg::SEL_PANEL)
        |=> reg_rdata == {pick($past(panel_mem[entry_index_bits]), $past(comp)), 4'h0})
        else $error("panel read wrong");

    crt_read_a: assert property (@(posedge mclk) disable iff (rst) // [R01]
        reg_rd && hit_val && table_select_bits == palette_pkg::SEL_CRT
        |=> reg_rdata == {pick($past(crt_mem[entry_index_bits]), $past(comp)), 4'h0})
        else $error("crt read wrong");

    select_read_a: assert property (@(posedge mclk) disable iff (rst) // [R01]
        reg_rd && hit_sel |=> reg_rdata == {6'h00, $past(table_select_bits)})
        else $error("select read wrong");

    index_read_a: assert property (@(posedge mclk) disable iff (rst) // [R03]
        reg_rd && hit_idx |=> reg_rdata == $past(entry_index_bits))
        else $error("index read wrong");

    low_nibble_a: assert property (@(posedge mclk) disable iff (rst) // [R06]
        reg_rd && hit_val |=> reg_rdata[3:0] == 4'h0)
        else $error("low nibble not zero");
endmodule : palette_table_access_port

// >>> testbench/palette_table_access_port_tb.sv
// Purpose: Self-checking bench for the colour table access port
// Assumes: Register reads answer the cycle after the read strobe; lookups answer one cycle after the index
// Notes:   Table contents are not reset, so every entry is written before it is looked at
module palette_table_access_port_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // Clock and reset
    logic                               mclk;
    logic                               rst;
    // Register port
    logic [palette_pkg::ADDR_W-1:0]     reg_addr;
    logic [palette_pkg::DATA_W-1:0]     reg_wdata;
    logic                               reg_wr;
    logic                               reg_rd;
    logic [palette_pkg::DATA_W-1:0]     reg_rdata;
    // Pixel lookups
    logic [7:0]                         panel_pix_idx;
    logic [11:0]                        panel_pix_rgb;
    logic [7:0]                         crt_pix_idx;
    logic [11:0]                        crt_pix_rgb;
    int                                 n_fail;
    int                                 tests_run;

    palette_table_access_port palette_table_access_port_i (
        .mclk          (mclk),
        .rst           (rst),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .panel_pix_idx (panel_pix_idx),
        .panel_pix_rgb (panel_pix_rgb),
        .crt_pix_idx   (crt_pix_idx),
        .crt_pix_rgb   (crt_pix_rgb)
    );

    // One clock stands in for both pixel clocks, so it runs through every table access
    always #5 mclk = ~mclk;

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        chk({4'h0, reg_rdata}, {4'h0, exp});
    endtask : rd

    // Low nibble of each value write is junk; it must be ignored
    task automatic trip(input logic [7:0] idx, input logic [11:0] rgb);
        wr(palette_pkg::OFF_INDEX, idx);
        wr(palette_pkg::OFF_VALUE, {rgb[11:8], 4'h5});
        wr(palette_pkg::OFF_VALUE, {rgb[7:4], 4'ha});
        wr(palette_pkg::OFF_VALUE, {rgb[3:0], 4'hf});
    endtask : trip

    task automatic pix(input logic [7:0] idx, input logic [11:0] ep, input logic [11:0] ec);
        @(posedge mclk);
        panel_pix_idx <= idx;
        crt_pix_idx   <= idx;
        repeat (2) @(posedge mclk);
        #1;
        chk(panel_pix_rgb, ep);
        chk(crt_pix_rgb, ec);
    endtask : pix

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    // Whole run is under two hundred cycles; this limit leaves wide margin
    initial begin
        #100us;
        n_fail++;
        report_and_stop();
    end

    initial begin
        mclk = 1'b0; rst = 1'b1; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0;
        panel_pix_idx = 8'h00; crt_pix_idx = 8'h00; n_fail = 0; tests_run = 0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        rd(palette_pkg::OFF_SELECT, 8'h00);
        rd(palette_pkg::OFF_INDEX, 8'h00);
        rd(9'h1e6, 8'h00);
        wr(palette_pkg::OFF_SELECT, 8'h00);
        trip(8'h03, 12'ha5f);
        pix(8'h03, 12'ha5f, 12'ha5f);
        wr(palette_pkg::OFF_INDEX, 8'h03);
        wr(palette_pkg::OFF_VALUE, 8'hc0);
        wr(palette_pkg::OFF_VALUE, 8'hd0);
        pix(8'h03, 12'ha5f, 12'ha5f);
        wr(palette_pkg::OFF_INDEX, 8'h03);
        wr(palette_pkg::OFF_VALUE, 8'h10);
        wr(palette_pkg::OFF_VALUE, 8'h20);
        wr(palette_pkg::OFF_VALUE, 8'h30);
        pix(8'h03, 12'h123, 12'h123);
        wr(palette_pkg::OFF_INDEX, 8'h03);
        rd(palette_pkg::OFF_VALUE, 8'h10);
        rd(palette_pkg::OFF_VALUE, 8'h20);
        rd(palette_pkg::OFF_VALUE, 8'h30);
        rd(palette_pkg::OFF_INDEX, 8'h04);
        wr(palette_pkg::OFF_SELECT, 8'h01);
        rd(palette_pkg::OFF_SELECT, 8'h01);
        trip(8'h03, 12'h456);
        pix(8'h03, 12'h456, 12'h123);
        wr(palette_pkg::OFF_INDEX, 8'h03);
        rd(palette_pkg::OFF_VALUE, 8'h40);
        wr(palette_pkg::OFF_SELECT, 8'h02);
        trip(8'h03, 12'h789);
        pix(8'h03, 12'h456, 12'h789);
        wr(palette_pkg::OFF_INDEX, 8'h03);
        rd(palette_pkg::OFF_VALUE, 8'h70);
        wr(palette_pkg::OFF_SELECT, 8'h00);
        wr(palette_pkg::OFF_INDEX, 8'h03);
        rd(palette_pkg::OFF_VALUE, 8'h40);
        // Reserved select: nothing commits, reads give zero, pointer still moves
        wr(palette_pkg::OFF_SELECT, 8'h03);
        trip(8'h03, 12'hbcd);
        pix(8'h03, 12'h456, 12'h789);
        wr(palette_pkg::OFF_INDEX, 8'h03);
        rd(palette_pkg::OFF_VALUE, 8'h00);
        rd(palette_pkg::OFF_VALUE, 8'h00);
        rd(palette_pkg::OFF_VALUE, 8'h00);
        rd(palette_pkg::OFF_INDEX, 8'h04);
        wr(palette_pkg::OFF_SELECT, 8'h00);
        trip(8'hff, 12'hedc);
        rd(palette_pkg::OFF_INDEX, 8'h00);
        pix(8'hff, 12'hedc, 12'hedc);
        // Reset mid-run with the pointer off red: outputs clear, pointer restarts at red of entry 0
        wr(palette_pkg::OFF_SELECT, 8'h02);
        wr(palette_pkg::OFF_INDEX, 8'h80);
        wr(palette_pkg::OFF_VALUE, 8'h60);
        @(posedge mclk);
        rst <= 1'b1;
        #1;
        chk(panel_pix_rgb, 12'h000);
        chk(crt_pix_rgb, 12'h000);
        chk({4'h0, reg_rdata}, 12'h000);
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(palette_pkg::OFF_SELECT, 8'h00);
        rd(palette_pkg::OFF_INDEX, 8'h00);
        wr(palette_pkg::OFF_VALUE, 8'h90);
        wr(palette_pkg::OFF_VALUE, 8'ha0);
        wr(palette_pkg::OFF_VALUE, 8'hb0);
        pix(8'h00, 12'h9ab, 12'h9ab);
        rd(palette_pkg::OFF_INDEX, 8'h01);
        report_and_stop();
    end
endmodule : palette_table_access_port_tb
